// [dv/cptd_card_model.sv]
`timescale 1ns/1ns
// card side: builds a template for one file kind and plays it byte by byte
module cptd_card_model
   import cptd_pkg::*;
(
   // clock
   input wire logic clk,
   // template byte stream
   output logic byte_valid,
   output logic [7:0] byte_data
);
   logic [7:0] q[$];

   // quiet line at start
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end

   // f: 0 legal, 1 drop commands object, 2 set b2, 3 bad char length, 4 overrun
   // f: 5 private first, 6 split group, 7 power in root, 8 size in root, 9 root tag in dir
   task automatic send(input cptd_kind_e k, input logic [7:0] ch, input int n,
      input logic [7:0] pc[5], input logic [7:0] pv[5], input logic [7:0] pf[5],
      input logic pr, input int f);
      q = {8'h80, (f == 3) ? 8'h02 : 8'h01, (f == 2) ? (ch | 8'h02) : (ch & 8'hfd)};
      if (f == 3) q.push_back(8'h00);
      for (int i = 0; i < n && k == CPTD_APPLICATION_FILE; i++) begin
         q = {q, 8'h81, 8'h03, pc[i], pv[i], pf[i]};
      end
      if (f == 7) q = {q, 8'h81, 8'h03, 8'h01, 8'h0a, 8'h0a};
      if (k == CPTD_ROOT_FILE && f != 1) q = {q, 8'h87, 8'h01, 8'h01};
      if (k == CPTD_ROOT_FILE || f == 9) q = {q, 8'h89, 8'h01, 8'h00};
      if (f == 6) q = {q, 8'h80, 8'h01, 8'h00};
      if (k == CPTD_ELEMENTARY_FILE_TLV || f == 8) q = {q, 8'h86, 8'h02, 8'h01, 8'h00};
      if (f == 5) q = {8'hc1, 8'h01, 8'h5a, q};
      else if (pr) q = {q, 8'hc1, 8'h01, 8'h5a};
      q = {8'ha5, 8'(q.size() - int'(f == 4)), q};
      foreach (q[i]) begin
         @(posedge clk);
         byte_valid <= 1'b1;
         byte_data <= q[i];
      end
      @(posedge clk);
      byte_valid <= 1'b0;
      byte_data <= ~q[q.size() - 1]; // no stale byte once released
   endtask
endmodule

// [dv/tb_card_prop_template_decoder.sv]
`timescale 1ns/1ns
module tb_card_prop_template_decoder
   import cptd_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic byte_valid, busy, done, error;
   logic [7:0] byte_data;
   logic [7:0] pc[5], pv[5], pf[5];
   logic [7:0] ch;
   logic [31:0] d;
   logic [2:0] cnt;
   int num_errors = 0;
   int checks_done = 0;
   int n;

   cptd_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .byte_valid(byte_valid),
      .byte_data(byte_data), .busy(busy), .done(done), .error(error));
   cptd_card_model card_u (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));

   // 250 MHz clock
   always #2 clk = ~clk;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // register bus master
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // expected characteristics word
   function automatic logic [31:0] exp_char(input logic [7:0] c);
      logic [1:0] m;
      m = c[0] ? 2'h3 : (c[2] & !c[3]) ? 2'h1 : (c[3] & !c[2]) ? 2'h2 : 2'h0;
      return {15'h0, c[7:4], c[0] ? c[3:2] : 2'h0, m, 1'b1, c};
   endfunction

   // expected power entry word
   function automatic logic [31:0] exp_pwr(input logic [7:0] k, input logic [7:0] c,
      input logic [7:0] f);
      return {6'h0, f != 8'hff, c != 8'h00 && c <= 8'h3c, k, 2'h0, c[5:0], f};
   endfunction

   // start a parse, play one template, let done land
   task automatic run(input cptd_kind_e k, input logic p, input int f);
      wr(4'h0, 32'h0000_0010 | 32'(k));
      #1 chk(busy, 1'b1, "busy");
      card_u.send(k, ch, n, pc, pv, pf, p, f);
      repeat (2) @(posedge clk);
      #1 chk(done, 1'b1, "done");
      chk(busy, 1'b0, "idle");
   endtask

   // hang guard
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial begin
      void'($urandom(76));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(4'h0, d);
      chk(d, 32'h0000_0000, "ctrl reset");
      @(posedge clk);
      #1 chk(reg_rdata, 32'h0000_0000, "rdata one cycle");
      wr(4'h7, 32'hffff_ffff);
      rd(4'h7, d);
      chk(d, 32'h0000_0000, "unmapped");
      rd(4'h3, d);
      chk(d, 32'h0000_0000, "pidx reset");
      // random legal templates over every file kind
      for (int t = 0; t < 15; t++) begin
         ch = $urandom;
         n = $urandom_range(0, 5);
         for (int i = 0; i < 5; i++) begin
            pc[i] = $urandom;
            pv[i] = $urandom;
            pf[i] = $urandom;
            if (pv[i][0]) pv[i] = (pv[i][2]) ? 8'h3d : (pv[i][1] ? 8'hff : 8'h3c);
            if (pf[i][7:6] == 2'h3) pf[i] = 8'hff;
            if (t == 1 && i == 0) pv[i] = 8'h00;
         end
         run(cptd_kind_e'(t % 5), t[0], 0);
         cnt = (t % 5 != 1) ? 3'h0 : (n > 4) ? 3'h4 : 3'(n);
         rd(4'h1, d);
         chk(d, {21'h0, cnt, 1'b0, t[0], 6'h02}, "status");
         chk(error, 1'b0, "error");
         rd(4'h2, d);
         chk(d, exp_char(ch & 8'hfd), "char");
         for (int i = 0; i < cnt; i++) begin
            wr(4'h3, 32'(i));
            repeat (2) @(posedge clk);
            rd(4'h4, d);
            chk(d, exp_pwr(pc[i], pv[i], pf[i]), "power");
         end
         $display("test %0d done", t);
      end
      // faults from the card side
      for (int f = 1; f < 10; f++) begin
         n = 0;
         run((f == 9) ? CPTD_DIRECTORY_FILE : CPTD_ROOT_FILE, 1'b0, f);
         rd(4'h1, d);
         cnt = (f == 2) ? 3'h5 : (f == 3 || f == 4) ? 3'h2 : (f > 4 && f < 7) ? 3'h3 : 3'h4;
         chk(d[cnt], 1'b1, "fault flag");
         chk(error, 1'b1, "error");
         $display("fault %0d done", f);
      end
      stop_test();
   end
endmodule

// [verilog/cptd_chk.sv]
`timescale 1ns/1ns
`include "cptd_defs.svh"
module cptd_chk
   import cptd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // characteristics byte
   input wire logic [7:0] char_i,
   input wire logic valid_i,
   // decoded fields
   output logic [1:0] stop_mode_o,
   output logic [1:0] pref_o,
   output logic [3:0] volt_o,
   output logic rsv_err_o
);
   logic [1:0] stop_mode_next;
   logic [1:0] pref_next;
   logic [3:0] volt_next;
   logic rsv_next;

   // clock stop policy and supply classes
   always_comb begin
      pref_next = 2'h0;
      if (char_i[0]) begin
         stop_mode_next = 2'h3;
         pref_next = {char_i[3], char_i[2]};
      end else if (char_i[3:2] == 2'b01) begin
         stop_mode_next = 2'h1;
      end else if (char_i[3:2] == 2'b10) begin
         stop_mode_next = 2'h2;
      end else begin
         stop_mode_next = 2'h0;
      end
      volt_next = char_i[7:4];
      rsv_next = valid_i & char_i[1];
   end

   // register decoded view
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_mode_o <= 2'h0;
         pref_o <= 2'h0;
         volt_o <= 4'h0;
         rsv_err_o <= 1'b0;
      end else begin
         stop_mode_o <= stop_mode_next;
         pref_o <= pref_next;
         volt_o <= volt_next;
         rsv_err_o <= rsv_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_rsv_bit_flag: assert property (valid_i && char_i[1] |=> rsv_err_o)
      else $error("reserved bit set but not flagged");
   a_never_stop: assert property (char_i[0] == 1'b0 && char_i[3:2] == 2'b00
      |=> stop_mode_o == 2'h0)
      else $error("clock stop allowed with all stop bits clear");
   a_free_stop_pref: assert property (char_i[0] |=> stop_mode_o == 2'h3
      && pref_o == $past(char_i[3:2]))
      else $error("free stop preference decoded wrong");
endmodule

// [verilog/cptd_defs.svh]
`ifndef CPTD_DEFS_SVH
`define CPTD_DEFS_SVH

// template and nested object tags
`define CPTD_TAG_TMPL 8'ha5
`define CPTD_TAG_CHAR 8'h80
`define CPTD_TAG_PWR 8'h81
`define CPTD_TAG_MAXSZ 8'h86
`define CPTD_TAG_SYSCMD 8'h87
`define CPTD_TAG_PLAT 8'h89
`define CPTD_TAG_LAST 8'h8b

// fixed object lengths and value limits
`define CPTD_LEN_CHAR 8'h01
`define CPTD_LEN_PWR 8'h03
`define CPTD_CONS_MAX 8'h3c
`define CPTD_BYTE_NONE 8'h00
`define CPTD_BYTE_FF 8'hff

// register offsets
`define CPTD_ADDR_CTRL 4'h0
`define CPTD_ADDR_STATUS 4'h1
`define CPTD_ADDR_CHAR 4'h2
`define CPTD_ADDR_PIDX 4'h3
`define CPTD_ADDR_PDATA 4'h4

// control field positions and reset values
`define CPTD_CTRL_GO_BIT 4
`define CPTD_CTRL_KIND_RST 3'h0
`define CPTD_PIDX_RST 2'h0

// seen-mask bit positions (tag minus 0x80)
`define CPTD_SEEN_CHAR 0
`define CPTD_SEEN_PWR 1
`define CPTD_SEEN_MAXSZ 6
`define CPTD_SEEN_SYSCMD 7

// power entry store
`define CPTD_PWR_DEPTH 4
`define CPTD_PWR_AW 2
`define CPTD_PWR_FULL 3'h4

`endif

// [verilog/cptd_mem.sv]
`timescale 1ns/1ns
`include "cptd_defs.svh"
module cptd_mem
   import cptd_pkg::*;
(
   // clock
   input wire logic clk,
   // storage port
   cptd_pwr_if.mem pw
);
   cptd_entry_t mem_arr [`CPTD_PWR_DEPTH];
   cptd_entry_t rd_reg;

   // write in arrival order, registered read
   always_ff @(posedge clk) begin
      if (pw.wr_en) begin
         mem_arr[pw.wr_addr] <= pw.wr_data;
      end
      rd_reg <= mem_arr[pw.rd_addr];
   end

   assign pw.rd_data = rd_reg;
endmodule

// [verilog/cptd_pkg.sv]
package cptd_pkg;
   // parser states, gray along the usual path
   typedef enum logic [2:0] {
      CPTD_IDLE = 3'h0,
      CPTD_OTAG = 3'h1,
      CPTD_OLEN = 3'h3,
      CPTD_ITAG = 3'h2,
      CPTD_ILEN = 3'h6,
      CPTD_IVAL = 3'h7,
      CPTD_DONE = 3'h5,
      CPTD_ERR = 3'h4
   } cptd_state_e;

   // kind of file the template was returned for
   typedef enum logic [2:0] {
      CPTD_ROOT_FILE = 3'h0,
      CPTD_APPLICATION_FILE = 3'h1,
      CPTD_DIRECTORY_FILE = 3'h2,
      CPTD_ELEMENTARY_FILE = 3'h3,
      CPTD_ELEMENTARY_FILE_TLV = 3'h4
   } cptd_kind_e;

   typedef logic [23:0] cptd_entry_t;
endpackage

// [verilog/cptd_pwr_if.sv]
`timescale 1ns/1ns
interface cptd_pwr_if;
   logic wr_en;
   logic [1:0] wr_addr;
   cptd_pkg::cptd_entry_t wr_data;
   logic [1:0] rd_addr;
   cptd_pkg::cptd_entry_t rd_data;

   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
   modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// [verilog/cptd_top.sv]
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "cptd_defs.svh"
module cptd_top
   import cptd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // template byte stream
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   // summary status
   output logic busy,
   output logic done,
   output logic error
);
   logic rst_s1_reg;
   logic rst_sync_n;
   cptd_state_e state_reg, state_next;
   cptd_kind_e kind_reg, kind_next;
   logic [7:0] rem_reg, rem_next;
   logic [7:0] vlen_reg, vlen_next;
   logic [7:0] tag_reg, tag_next;
   logic [11:0] seen_reg, seen_next;
   logic priv_reg, priv_next;
   logic efmt_reg, efmt_next;
   logic eord_reg, eord_next;
   logic epres_reg, epres_next;
   logic [7:0] char_reg, char_next;
   logic charv_reg, charv_next;
   cptd_entry_t pbuf_reg, pbuf_next;
   logic [2:0] pcnt_reg, pcnt_next;
   logic pw_en_reg, pw_en_next;
   logic [1:0] pw_addr_reg, pw_addr_next;
   cptd_entry_t pw_data_reg, pw_data_next;
   logic [1:0] pidx_reg, pidx_next;
   logic [31:0] rdata_next;
   logic busy_next, done_next, error_next;
   logic go;
   logic fin;
   logic [7:0] rem_less;
   logic [1:0] stop_mode;
   logic [1:0] pref;
   logic [3:0] volt;
   logic rsv_err;
   cptd_entry_t entry;
   cptd_pwr_if pw ();

   // standard nested tag 80..8B
   function automatic logic is_std(input logic [7:0] t);
      return (t >= `CPTD_TAG_CHAR) && (t <= `CPTD_TAG_LAST);
   endfunction

   // private tag: b8 and b7 both set
   function automatic logic is_private(input logic [7:0] t);
      return t[7:6] == 2'b11;
   endfunction

   // seen-mask position of a standard tag
   function automatic logic [3:0] tag_idx(input logic [7:0] t);
      return t[3:0];
   endfunction

   // reset: async assert, two-flop release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_sync_n <= rst_s1_reg;
      end
   end

   assign go = reg_wr && (reg_addr == `CPTD_ADDR_CTRL) && reg_wdata[`CPTD_CTRL_GO_BIT];
   assign rem_less = rem_reg - 8'h01;

   // template parser next state
   always_comb begin
      state_next = state_reg;
      kind_next = kind_reg;
      rem_next = rem_reg;
      vlen_next = vlen_reg;
      tag_next = tag_reg;
      seen_next = seen_reg;
      priv_next = priv_reg;
      efmt_next = efmt_reg;
      eord_next = eord_reg;
      epres_next = epres_reg;
      char_next = char_reg;
      charv_next = charv_reg;
      pbuf_next = pbuf_reg;
      pcnt_next = pcnt_reg;
      pw_en_next = 1'b0;
      pw_addr_next = pw_addr_reg;
      pw_data_next = pw_data_reg;
      fin = 1'b0;
      if (go) begin
         state_next = CPTD_OTAG;
         kind_next = cptd_kind_e'(reg_wdata[2:0]);
         seen_next = 12'h000;
         priv_next = 1'b0;
         efmt_next = 1'b0;
         eord_next = 1'b0;
         epres_next = 1'b0;
         charv_next = 1'b0;
         pcnt_next = 3'h0;
         tag_next = 8'h00;
      end else if (byte_valid) begin
         case (state_reg)
            CPTD_OTAG: begin
               if (byte_data == `CPTD_TAG_TMPL) begin
                  state_next = CPTD_OLEN;
               end else begin
                  efmt_next = 1'b1;
                  state_next = CPTD_ERR;
               end
            end
            CPTD_OLEN: begin
               rem_next = byte_data;
               if (byte_data[7]) begin
                  efmt_next = 1'b1;
                  state_next = CPTD_ERR;
               end else if (byte_data == 8'h00) begin
                  fin = 1'b1;
               end else begin
                  state_next = CPTD_ITAG;
               end
            end
            CPTD_ITAG: begin
               rem_next = rem_less;
               tag_next = byte_data;
               if (rem_reg == 8'h01) begin
                  efmt_next = 1'b1;
                  state_next = CPTD_ERR;
               end else begin
                  state_next = CPTD_ILEN;
               end
               if (is_private(byte_data)) begin
                  priv_next = 1'b1;
               end else begin
                  if (priv_reg) begin
                     eord_next = 1'b1;
                  end
                  if (is_std(byte_data)) begin
                     if (seen_reg[tag_idx(byte_data)] && byte_data != tag_reg) begin
                        eord_next = 1'b1;
                     end
                     seen_next[tag_idx(byte_data)] = 1'b1;
                  end
                  if (byte_data == `CPTD_TAG_PWR && kind_reg != CPTD_APPLICATION_FILE) begin
                     epres_next = 1'b1;
                  end
                  if (byte_data >= `CPTD_TAG_PLAT && byte_data <= `CPTD_TAG_LAST
                      && kind_reg != CPTD_ROOT_FILE) begin
                     epres_next = 1'b1;
                  end
                  if (byte_data == `CPTD_TAG_MAXSZ && kind_reg != CPTD_ELEMENTARY_FILE_TLV) begin
                     epres_next = 1'b1;
                  end
               end
            end
            CPTD_ILEN: begin
               rem_next = rem_less;
               vlen_next = byte_data;
               if (byte_data[7] || byte_data > rem_less) begin
                  efmt_next = 1'b1;
                  state_next = CPTD_ERR;
               end else if ((tag_reg == `CPTD_TAG_CHAR && byte_data != `CPTD_LEN_CHAR)
                  || (tag_reg == `CPTD_TAG_PWR && byte_data != `CPTD_LEN_PWR)) begin
                  efmt_next = 1'b1;
                  state_next = CPTD_ERR;
               end else if (byte_data == 8'h00) begin
                  if (rem_less == 8'h00) begin
                     fin = 1'b1;
                  end else begin
                     state_next = CPTD_ITAG;
                  end
               end else begin
                  state_next = CPTD_IVAL;
               end
            end
            CPTD_IVAL: begin
               rem_next = rem_less;
               vlen_next = vlen_reg - 8'h01;
               pbuf_next = {pbuf_reg[15:0], byte_data};
               if (tag_reg == `CPTD_TAG_CHAR) begin
                  char_next = byte_data;
                  charv_next = 1'b1;
               end
               if (vlen_reg == 8'h01) begin
                  if (tag_reg == `CPTD_TAG_PWR && pcnt_reg != `CPTD_PWR_FULL) begin
                     pw_en_next = 1'b1;
                     pw_addr_next = pcnt_reg[1:0];
                     pw_data_next = {pbuf_reg[15:0], byte_data};
                     pcnt_next = pcnt_reg + 3'h1;
                  end
                  if (rem_reg == 8'h01) begin
                     fin = 1'b1;
                  end else begin
                     state_next = CPTD_ITAG;
                  end
               end
            end
            default: begin
               state_next = state_reg;
            end
         endcase
         if (fin) begin
            state_next = CPTD_DONE;
            if (kind_reg == CPTD_ROOT_FILE && (!seen_next[`CPTD_SEEN_CHAR]
                || !seen_next[`CPTD_SEEN_SYSCMD])) begin
               epres_next = 1'b1;
            end
         end
      end
      busy_next = (state_next != CPTD_IDLE) && (state_next != CPTD_DONE)
         && (state_next != CPTD_ERR);
      done_next = (state_next == CPTD_DONE) || (state_next == CPTD_ERR);
      error_next = efmt_next | eord_next | epres_next | rsv_err;
   end

   // parser registers
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= CPTD_IDLE;
         kind_reg <= cptd_kind_e'(`CPTD_CTRL_KIND_RST);
         rem_reg <= 8'h00;
         vlen_reg <= 8'h00;
         tag_reg <= 8'h00;
         seen_reg <= 12'h000;
         priv_reg <= 1'b0;
         efmt_reg <= 1'b0;
         eord_reg <= 1'b0;
         epres_reg <= 1'b0;
         char_reg <= 8'h00;
         charv_reg <= 1'b0;
         pbuf_reg <= 24'h00_0000;
         pcnt_reg <= 3'h0;
         pw_en_reg <= 1'b0;
         pw_addr_reg <= 2'h0;
         pw_data_reg <= 24'h00_0000;
         busy <= 1'b0;
         done <= 1'b0;
         error <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         rem_reg <= rem_next;
         vlen_reg <= vlen_next;
         tag_reg <= tag_next;
         seen_reg <= seen_next;
         priv_reg <= priv_next;
         efmt_reg <= efmt_next;
         eord_reg <= eord_next;
         epres_reg <= epres_next;
         char_reg <= char_next;
         charv_reg <= charv_next;
         pbuf_reg <= pbuf_next;
         pcnt_reg <= pcnt_next;
         pw_en_reg <= pw_en_next;
         pw_addr_reg <= pw_addr_next;
         pw_data_reg <= pw_data_next;
         busy <= busy_next;
         done <= done_next;
         error <= error_next;
      end
   end

   // power entry store hookup
   assign pw.wr_en = pw_en_reg;
   assign pw.wr_addr = pw_addr_reg;
   assign pw.wr_data = pw_data_reg;
   assign pw.rd_addr = pidx_reg;
   assign entry = pw.rd_data;

   cptd_mem u_mem (
      .clk(clk),
      .pw(pw)
   );

   cptd_chk u_chk (
      .clk(clk),
      .rst_n(rst_sync_n),
      .char_i(char_reg),
      .valid_i(charv_reg),
      .stop_mode_o(stop_mode),
      .pref_o(pref),
      .volt_o(volt),
      .rsv_err_o(rsv_err)
   );

   // register read mux and index write
   always_comb begin
      pidx_next = pidx_reg;
      if (reg_wr && reg_addr == `CPTD_ADDR_PIDX) begin
         pidx_next = reg_wdata[1:0];
      end
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `CPTD_ADDR_CTRL: rdata_next = {29'h0000_0000, kind_reg};
            `CPTD_ADDR_STATUS: rdata_next = {21'h00_0000, pcnt_reg, 1'b0, priv_reg,
               rsv_err, epres_reg, eord_reg, efmt_reg, done, busy};
            `CPTD_ADDR_CHAR: rdata_next = {15'h0000, volt, pref, stop_mode, charv_reg,
               char_reg};
            `CPTD_ADDR_PIDX: rdata_next = {30'h0000_0000, pidx_reg};
            `CPTD_ADDR_PDATA: rdata_next = {6'h00,
               entry[7:0] != `CPTD_BYTE_FF,
               entry[15:8] != `CPTD_BYTE_NONE && entry[15:8] <= `CPTD_CONS_MAX,
               entry[23:16], 2'b00, entry[13:8], entry[7:0]};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // register port flops
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pidx_reg <= `CPTD_PIDX_RST;
         reg_rdata <= 32'h0000_0000;
      end else begin
         pidx_reg <= pidx_next;
         reg_rdata <= rdata_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n);

   a_outer_tag_bad: assert property (!go && byte_valid && state_reg == CPTD_OTAG
      && byte_data != `CPTD_TAG_TMPL |=> state_reg == CPTD_ERR && efmt_reg)
      else $error("bad template tag accepted");
   a_len_overrun: assert property (!go && byte_valid && state_reg == CPTD_ILEN
      && byte_data > rem_reg - 8'h01 |=> efmt_reg ##1 done)
      else $error("overrunning length not flagged");
   a_char_len: assert property (!go && byte_valid && state_reg == CPTD_ILEN
      && tag_reg == `CPTD_TAG_CHAR && byte_data != `CPTD_LEN_CHAR |=> efmt_reg)
      else $error("characteristics length not checked");
   a_pwr_len: assert property (!go && byte_valid && state_reg == CPTD_ILEN
      && tag_reg == `CPTD_TAG_PWR && byte_data != `CPTD_LEN_PWR |=> efmt_reg)
      else $error("power length not checked");
   a_private_order: assert property (!go && byte_valid && state_reg == CPTD_ITAG
      && priv_reg && !is_private(byte_data) |=> eord_reg ##1 error)
      else $error("standard after private not flagged");
   a_group_order: assert property (!go && byte_valid && state_reg == CPTD_ITAG
      && is_std(byte_data) && seen_reg[tag_idx(byte_data)] && byte_data != tag_reg
      |=> eord_reg)
      else $error("split repeated tag not flagged");
   a_root_char: assert property (state_reg == CPTD_DONE && kind_reg == CPTD_ROOT_FILE
      && !seen_reg[`CPTD_SEEN_CHAR] |-> epres_reg)
      else $error("missing characteristics not flagged");
   a_root_cmds: assert property (state_reg == CPTD_DONE && kind_reg == CPTD_ROOT_FILE
      && !seen_reg[`CPTD_SEEN_SYSCMD] |-> epres_reg)
      else $error("missing system commands not flagged");
   a_app_power: assert property (state_reg == CPTD_DONE && seen_reg[`CPTD_SEEN_PWR]
      && kind_reg != CPTD_APPLICATION_FILE |-> epres_reg)
      else $error("power object outside application not flagged");
   a_root_only: assert property (state_reg == CPTD_DONE && seen_reg[11:9] != 3'h0
      && kind_reg != CPTD_ROOT_FILE |-> epres_reg)
      else $error("root-only tag not flagged");
   a_max_size: assert property (state_reg == CPTD_DONE && seen_reg[`CPTD_SEEN_MAXSZ]
      && kind_reg != CPTD_ELEMENTARY_FILE_TLV |-> epres_reg)
      else $error("maximum size object misplaced not flagged");
   a_pwr_store: assert property (pw_en_reg |-> pw_addr_reg == $past(pcnt_reg[1:0])
      && pcnt_reg == $past(pcnt_reg) + 3'h1)
      else $error("power entry not stored in order");

   c_root_done: cover property (state_reg == CPTD_DONE && kind_reg == CPTD_ROOT_FILE
      && !error);
   c_fmt_err: cover property (state_reg == CPTD_ERR);
   c_two_power: cover property (pw_en_reg && pw_addr_reg == 2'h1);
   c_private: cover property (priv_reg && state_reg == CPTD_DONE);
endmodule
